// file: rtl/alarm_seq_pkg.sv
package alarm_seq_pkg;

  // ------------------------------------------------------------
  // timebase
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned QTICK_MS        = 250;
  localparam int unsigned QTICK_CYCLES    = CLK_HZ / 1000 * QTICK_MS;
  localparam int unsigned QTICK_PER_SEC   = 4;

  // ------------------------------------------------------------
  // delay and escalation times, seconds
  // ------------------------------------------------------------
  localparam logic [7:0] PRESIGNAL_MIN_S  = 8'h3C;
  localparam logic [7:0] PRESIGNAL_MAX_S  = 8'hB4;
  localparam logic [7:0] PAS_WINDOW_S     = 8'h0F;
  localparam logic [9:0] TWO_STAGE_S      = 10'h12C;
  localparam logic [9:0] CANADA3_S        = 10'h0B4;
  localparam logic [9:0] CANADA5_S        = 10'h12C;

  // ------------------------------------------------------------
  // pattern phases, quarter seconds; window sensitivity level
  // ------------------------------------------------------------
  localparam logic [5:0] MARCH_PERIOD_Q   = 6'h02;
  localparam logic [5:0] MARCH_ON_Q       = 6'h01;
  localparam logic [5:0] TEMP_STEP_Q      = 6'h02;
  localparam logic [5:0] TEMP_PERIOD_Q    = 6'h10;
  localparam logic [5:0] TEMP_ON_END_Q    = 6'h0A;
  localparam logic [5:0] CALIF_PERIOD_Q   = 6'h3C;
  localparam logic [5:0] CALIF_ON_Q       = 6'h28;
  localparam logic [5:0] ALERT_PERIOD_Q   = 6'h0C;
  localparam logic [5:0] ALERT_ON_Q       = 6'h06;
  localparam logic [3:0] LEAST_SENSITIVE_LEVEL = 4'h9;

  // ------------------------------------------------------------
  // global coding selection
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CODE_MARCH      = 4'h0,
    CODE_TEMPORAL   = 4'h1,
    CODE_CALIFORNIA = 4'h2,
    CODE_TWO_STAGE  = 4'h3,
    CODE_CANADA3    = 4'h4,
    CODE_CANADA5    = 4'h5,
    CODE_CANADA_MAN = 4'h6,
    CODE_SYNC_A     = 4'h7,
    CODE_SYNC_B     = 4'h8,
    CODE_SYNC_C     = 4'h9
  } coding_sel_t;

  // panel events, one-cycle pulses except drill
  typedef struct packed {
    logic alarm;
    logic alarm_in_presignal_zone;
    logic acknowledge;
    logic silence;
    logic horn_silence;
    logic panel_reset;
    logic evacuate_input;
    logic event_list_general;
  } panel_evt_t;

  // time-of-day window status from the calendar
  typedef struct packed {
    logic [6:0] day_onehot;
    logic       holiday_today;
    logic       win_a_in_time;
    logic       win_b_in_time;
    logic [7:0] win_a_days;
    logic [7:0] win_b_days;
  } time_win_t;

  typedef struct packed {
    logic general_alarm_relay;
    logic polarity_reversal;
    logic municipal_box;
    logic communicator;
  } remote_out_t;

endpackage : alarm_seq_pkg

// file: rtl/pattern_gen.sv
// quarter-second pattern generator for one coded output
module pattern_gen (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       qtick,
  input  wire logic                       run,
  input  wire alarm_seq_pkg::coding_sel_t sel,
  input  wire logic                       second_stage,
  output logic                            pulse
);

  logic [5:0] phase_q;
  logic [5:0] period;
  logic       on_d;

  // ------------------------------------------------------------
  // pattern shape
  // ------------------------------------------------------------
  // two-stage modes use alert pulsing until escalated
  always_comb begin
    period = alarm_seq_pkg::MARCH_PERIOD_Q;
    on_d   = phase_q < alarm_seq_pkg::MARCH_ON_Q;
    unique case (sel)
      alarm_seq_pkg::CODE_TEMPORAL: begin
        period = alarm_seq_pkg::TEMP_PERIOD_Q;
        on_d   = (phase_q < alarm_seq_pkg::TEMP_ON_END_Q) && !phase_q[1];
      end
      alarm_seq_pkg::CODE_CALIFORNIA: begin
        period = alarm_seq_pkg::CALIF_PERIOD_Q;
        on_d   = phase_q < alarm_seq_pkg::CALIF_ON_Q;
      end
      alarm_seq_pkg::CODE_TWO_STAGE, alarm_seq_pkg::CODE_CANADA3,
      alarm_seq_pkg::CODE_CANADA5, alarm_seq_pkg::CODE_CANADA_MAN: begin
        if (second_stage) begin
          period = alarm_seq_pkg::TEMP_PERIOD_Q;
          on_d   = (phase_q < alarm_seq_pkg::TEMP_ON_END_Q) && !phase_q[1];
        end else begin
          period = alarm_seq_pkg::ALERT_PERIOD_Q;
          on_d   = phase_q < alarm_seq_pkg::ALERT_ON_Q;
        end
      end
      alarm_seq_pkg::CODE_SYNC_A, alarm_seq_pkg::CODE_SYNC_B, alarm_seq_pkg::CODE_SYNC_C: begin
        period = alarm_seq_pkg::MARCH_PERIOD_Q;
        on_d   = 1'b1; // steady, appliances pace themselves
      end
      default: begin
        period = alarm_seq_pkg::MARCH_PERIOD_Q;
        on_d   = phase_q < alarm_seq_pkg::MARCH_ON_Q;
      end
    endcase
  end

  // phase counter restarts whenever the output idles
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= 6'h00;
    end else if (!run) begin
      phase_q <= 6'h00;
    end else if (qtick) begin
      phase_q <= (phase_q + 6'h01 >= period) ? 6'h00 : phase_q + 6'h01;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= run && on_d;
    end
  end

endmodule : pattern_gen

// file: rtl/alarm_output_sequencer.sv
// ------------------------------------------------------------
// alarm output sequencer
// ------------------------------------------------------------
// Overview of operation
// - presignal delay programmable from 60 to 180 s
// - remote outputs bypass presignal delay normally
// - positive sequence outputs wait 15 s first
// - acknowledge in window extends to full delay
// - presignal-zone source also delays remote outputs
// - window outputs active only in time, days
// - window smoke detectors drop to level 9
// - holidays suppress window unless holiday selected
// - window outputs forced off during reset, programming
// - one global pattern for all coded circuits
// - march time pulses at 120 per minute
// - temporal is three half-second pulses, 1.5 s gap
// - California is 10 s on, 5 s off
// - two-stage alert 20 per minute, then temporal
// - two-stage escalates after five silent minutes
// - Canadian timed escalate on timer, drill, event list
// - Canadian acknowledge holds first stage; alarm restarts
// - Canadian manual escalates only on drill, event
// - strobe sync on main circuits; horn-only silence
// - unacknowledged positive sequence releases all outputs
// - second alarm aborts presignal delay immediately
// - system reset stops presignal countdown
module alarm_output_sequencer #(
  parameter int unsigned NUM_CIRCUITS = 4,
  parameter int unsigned QTICK_CYCLES = alarm_seq_pkg::QTICK_CYCLES
) (
  input  wire logic                       core_clk,
  input  wire logic                       sys_rst,
  input  wire alarm_seq_pkg::panel_evt_t  evt,
  input  wire alarm_seq_pkg::time_win_t   tw,
  input  wire logic                       programming,
  input  wire logic [7:0]                 presignal_seconds,
  input  wire logic                       positive_alarm_sequence,
  input  wire alarm_seq_pkg::coding_sel_t coding_sel,
  input  wire logic [NUM_CIRCUITS-1:0]    circuit_coded,
  input  wire logic [NUM_CIRCUITS-1:0]    circuit_presignal,
  input  wire logic [NUM_CIRCUITS-1:0]    circuit_pas,
  input  wire logic [NUM_CIRCUITS-1:0]    circuit_win_a,
  input  wire logic [NUM_CIRCUITS-1:0]    circuit_win_b,
  input  wire logic [NUM_CIRCUITS-1:0]    circuit_strobe,
  input  wire logic [NUM_CIRCUITS-1:0]    circuit_main_board,
  output logic [NUM_CIRCUITS-1:0]         notification_circuit,
  output logic [NUM_CIRCUITS-1:0]         horn_enable,
  output alarm_seq_pkg::remote_out_t      remote_out,
  output logic                            win_a_active,
  output logic                            win_b_active,
  output logic [3:0]                      win_sensitivity_level,
  output logic                            delay_running,
  output logic                            second_stage
);

  typedef enum logic [1:0] {
    DLY_IDLE  = 2'b00,
    DLY_PAS   = 2'b01,
    DLY_FULL  = 2'b11,
    DLY_DONE  = 2'b10
  } delay_state_t;

  delay_state_t delay_q;
  logic [QTICK_CYCLES > 1 ? $clog2(QTICK_CYCLES)-1 : 0 : 0] div_q;
  logic       qtick;
  logic [1:0] qcnt_q;
  logic       stick;
  logic [7:0] dly_sec_q;
  logic [7:0] dly_limit;
  logic       alarm_q;
  logic       sourced_in_zone_q;
  logic       stage2_q;
  logic       held_q;
  logic       cancel_q;
  logic [9:0] esc_sec_q;
  logic [9:0] esc_limit;
  logic       timed_mode;
  logic       two_stage_mode;
  logic       sync_mode;
  logic       local_release;
  logic       remote_release;
  logic       ack_or_sil;
  logic       horn_muted_q;
  logic       win_a_d;
  logic       win_b_d;

  // ------------------------------------------------------------
  // timebase
  // ------------------------------------------------------------
  // one divider feeds both ticks so phases never drift apart
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_q <= '0;
    end else if (qtick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign qtick = (32'(div_q) == QTICK_CYCLES - 1);

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      qcnt_q <= 2'h0;
    end else if (qtick) begin
      qcnt_q <= qcnt_q + 2'h1;
    end
  end

  assign stick = qtick && (qcnt_q == 2'(alarm_seq_pkg::QTICK_PER_SEC - 1));

  // ------------------------------------------------------------
  // alarm latch
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_q           <= 1'b0;
      sourced_in_zone_q <= 1'b0;
    end else if (evt.panel_reset) begin
      alarm_q           <= 1'b0;
      sourced_in_zone_q <= 1'b0;
    end else if (evt.alarm) begin
      alarm_q           <= 1'b1;
      sourced_in_zone_q <= sourced_in_zone_q | (!alarm_q && evt.alarm_in_presignal_zone);
    end
  end

  // ------------------------------------------------------------
  // presignal and positive sequence delay
  // ------------------------------------------------------------
  // programmed value clamped so a bad entry cannot remove the delay
  always_comb begin
    dly_limit = presignal_seconds;
    if (presignal_seconds < alarm_seq_pkg::PRESIGNAL_MIN_S) begin
      dly_limit = alarm_seq_pkg::PRESIGNAL_MIN_S;
    end else if (presignal_seconds > alarm_seq_pkg::PRESIGNAL_MAX_S) begin
      dly_limit = alarm_seq_pkg::PRESIGNAL_MAX_S;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      delay_q   <= DLY_IDLE;
      dly_sec_q <= 8'h00;
    end else if (evt.panel_reset) begin
      delay_q   <= DLY_IDLE;
      dly_sec_q <= 8'h00;
    end else begin
      unique case (delay_q)
        DLY_IDLE: begin
          if (evt.alarm && !alarm_q) begin
            delay_q   <= positive_alarm_sequence ? DLY_PAS : DLY_FULL;
            dly_sec_q <= 8'h00;
          end
        end
        DLY_PAS: begin
          if (evt.alarm) begin
            delay_q <= DLY_DONE;
          end else if (evt.acknowledge) begin
            delay_q <= DLY_FULL;
          end else if (stick) begin
            dly_sec_q <= dly_sec_q + 8'h01;
            if (dly_sec_q + 8'h01 >= alarm_seq_pkg::PAS_WINDOW_S) begin
              delay_q <= DLY_DONE;
            end
          end
        end
        DLY_FULL: begin
          if (evt.alarm) begin
            delay_q <= DLY_DONE;
          end else if (stick) begin
            dly_sec_q <= dly_sec_q + 8'h01;
            if (dly_sec_q + 8'h01 >= dly_limit) begin
              delay_q <= DLY_DONE;
            end
          end
        end
        DLY_DONE: begin
          delay_q <= DLY_DONE;
        end
      endcase
    end
  end

  assign delay_running  = (delay_q == DLY_PAS) || (delay_q == DLY_FULL);
  assign local_release  = alarm_q && !delay_running;
  // remote outputs wait only when the source sits in the presignal zone
  assign remote_release = alarm_q && (!sourced_in_zone_q || !delay_running);

  // ------------------------------------------------------------
  // two-stage escalation
  // ------------------------------------------------------------
  assign two_stage_mode = (coding_sel == alarm_seq_pkg::CODE_TWO_STAGE) ||
                          (coding_sel == alarm_seq_pkg::CODE_CANADA3) ||
                          (coding_sel == alarm_seq_pkg::CODE_CANADA5) ||
                          (coding_sel == alarm_seq_pkg::CODE_CANADA_MAN);
  assign timed_mode     = two_stage_mode && (coding_sel != alarm_seq_pkg::CODE_CANADA_MAN);
  assign sync_mode      = (coding_sel == alarm_seq_pkg::CODE_SYNC_A) ||
                          (coding_sel == alarm_seq_pkg::CODE_SYNC_B) ||
                          (coding_sel == alarm_seq_pkg::CODE_SYNC_C);
  assign ack_or_sil     = evt.acknowledge || evt.silence;

  always_comb begin
    unique case (coding_sel)
      alarm_seq_pkg::CODE_CANADA3: esc_limit = alarm_seq_pkg::CANADA3_S;
      alarm_seq_pkg::CODE_CANADA5: esc_limit = alarm_seq_pkg::CANADA5_S;
      default:                     esc_limit = alarm_seq_pkg::TWO_STAGE_S;
    endcase
  end

  // timer counts while an alarm is latched in a timed mode and nobody has answered
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      esc_sec_q <= 10'h000;
      held_q    <= 1'b0;
    end else if (evt.panel_reset || !alarm_q) begin
      esc_sec_q <= 10'h000;
      held_q    <= 1'b0;
    end else if (evt.alarm && coding_sel != alarm_seq_pkg::CODE_TWO_STAGE) begin
      esc_sec_q <= 10'h000;
      held_q    <= ack_or_sil; // an answer in the same cycle still holds
    end else if (ack_or_sil) begin
      held_q    <= 1'b1;
    end else if (stick && !held_q && timed_mode) begin
      esc_sec_q <= esc_sec_q + 10'h001;
    end
  end

  // manual variant: reset or silence before escalation cancels it
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cancel_q <= 1'b0;
    end else if (!alarm_q && !evt.alarm) begin
      cancel_q <= 1'b0;
    end else if ((evt.panel_reset || evt.silence) && !stage2_q) begin
      cancel_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage2_q <= 1'b0;
    end else if (evt.panel_reset || !two_stage_mode) begin
      stage2_q <= 1'b0;
    end else if (timed_mode && !held_q && esc_sec_q >= esc_limit) begin
      stage2_q <= 1'b1;
    end else if (coding_sel != alarm_seq_pkg::CODE_TWO_STAGE &&
                 (evt.evacuate_input || evt.event_list_general) &&
                 !(coding_sel == alarm_seq_pkg::CODE_CANADA_MAN && cancel_q)) begin
      stage2_q <= 1'b1;
    end
  end

  assign second_stage = stage2_q;

  // ------------------------------------------------------------
  // time control windows
  // ------------------------------------------------------------
  // day match; holiday overrides unless the holiday bit is chosen
  assign win_a_d = tw.win_a_in_time && !programming && !evt.panel_reset &&
                   ((tw.holiday_today) ? tw.win_a_days[7] : |(tw.win_a_days[6:0] & tw.day_onehot));
  assign win_b_d = tw.win_b_in_time && !programming && !evt.panel_reset &&
                   ((tw.holiday_today) ? tw.win_b_days[7] : |(tw.win_b_days[6:0] & tw.day_onehot));

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      win_a_active          <= 1'b0;
      win_b_active          <= 1'b0;
      win_sensitivity_level <= 4'h0;
    end else begin
      win_a_active          <= win_a_d;
      win_b_active          <= win_b_d;
      win_sensitivity_level <= (win_a_d || win_b_d) ? alarm_seq_pkg::LEAST_SENSITIVE_LEVEL : 4'h0;
    end
  end

  // ------------------------------------------------------------
  // remote outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      remote_out <= '0;
    end else begin
      remote_out <= {4{remote_release}};
    end
  end

  // horn-only silence latched until a fresh fire alarm resounds
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      horn_muted_q <= 1'b0;
    end else if (evt.horn_silence) begin
      horn_muted_q <= 1'b1;
    end else if (evt.alarm || evt.panel_reset) begin
      horn_muted_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // per-circuit output
  // ------------------------------------------------------------
  for (genvar i = 0; i < NUM_CIRCUITS; i++) begin : g_circ
    logic run;
    logic coded;
    logic gate_ok;
    logic on_d;

    assign gate_ok = (!circuit_win_a[i] || win_a_active) && (!circuit_win_b[i] || win_b_active);
    assign run     = (circuit_presignal[i] || circuit_pas[i]) ? local_release : alarm_q;
    // sync codes only exist on main board circuits
    assign on_d    = run && gate_ok &&
                     !(two_stage_mode && coding_sel == alarm_seq_pkg::CODE_CANADA_MAN && cancel_q && !stage2_q &&
                       evt.silence);

    pattern_gen u_pat (
      .core_clk     (core_clk),
      .sys_rst      (sys_rst),
      .qtick        (qtick),
      .run          (on_d && circuit_coded[i] && (!sync_mode || circuit_main_board[i])),
      .sel          (coding_sel),
      .second_stage (stage2_q),
      .pulse        (coded)
    );

    always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
        notification_circuit[i] <= 1'b0;
        horn_enable[i]          <= 1'b0;
      end else begin
        notification_circuit[i] <= circuit_coded[i] ? coded : on_d;
        horn_enable[i]          <= on_d && !(circuit_strobe[i] && sync_mode && circuit_main_board[i] &&
                                             horn_muted_q);
      end
    end
  end

endmodule : alarm_output_sequencer

// file: test/alarm_seq_properties.sv
module alarm_seq_checker #(
  parameter int unsigned NUM_CIRCUITS = 4,
  parameter int unsigned QTICK_CYCLES = 4
) (
  input wire logic                       core_clk,
  input wire logic                       sys_rst,
  input wire alarm_seq_pkg::panel_evt_t  evt,
  input wire alarm_seq_pkg::time_win_t   tw,
  input wire logic                       programming,
  input wire logic                       positive_alarm_sequence,
  input wire alarm_seq_pkg::coding_sel_t coding_sel,
  input wire logic [NUM_CIRCUITS-1:0]    circuit_coded,
  input wire logic [NUM_CIRCUITS-1:0]    notification_circuit,
  input wire alarm_seq_pkg::remote_out_t remote_out,
  input wire logic                       win_a_active,
  input wire logic                       win_b_active,
  input wire logic [3:0]                 win_sensitivity_level,
  input wire logic                       delay_running,
  input wire logic                       second_stage
);
  localparam int unsigned DLY_MAX = 180 * 4 * QTICK_CYCLES + 16;
  logic [15:0] hi_q;
  logic [15:0] dly_q;
  logic        seen_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // run lengths; first pulse after an alarm may be cut by tick phase
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_q   <= '0;
      dly_q  <= '0;
      seen_q <= 1'b0;
    end else begin
      hi_q   <= notification_circuit[0] ? hi_q + 16'h0001 : 16'h0000;
      dly_q  <= delay_running ? dly_q + 16'h0001 : 16'h0000;
      seen_q <= !evt.panel_reset && (seen_q || (hi_q != 16'h0000 && !notification_circuit[0]));
    end
  end

  AST_REMOTE_BYPASS: assert property (evt.alarm && !evt.alarm_in_presignal_zone && !evt.panel_reset
    && !positive_alarm_sequence |-> ##2 remote_out == 4'hF) else $error("remote outputs late");
  AST_ZONE_HOLD: assert property (evt.alarm && evt.alarm_in_presignal_zone && !delay_running
    && remote_out == 4'h0 |-> ##2 remote_out == 4'h0) else $error("zone alarm not delayed");
  AST_ABORT: assert property (delay_running && evt.alarm && !evt.panel_reset
    |-> ##2 remote_out == 4'hF) else $error("second alarm did not abort");
  AST_RESET_STOP: assert property (evt.panel_reset |=> !delay_running && !second_stage
    ##1 remote_out == 4'h0) else $error("reset did not stop");
  AST_DELAY_MAX: assert property (dly_q <= DLY_MAX) else $error("delay too long");
  AST_WIN_FORCE: assert property (programming || evt.panel_reset
    |=> !win_a_active && !win_b_active) else $error("window on during reset");
  AST_WIN_TIME: assert property (!tw.win_a_in_time |=> !win_a_active) else $error("window out of time");
  AST_HOLIDAY: assert property (tw.holiday_today && !tw.win_a_days[7]
    |=> !win_a_active) else $error("holiday not suppressed");
  AST_LEVEL: assert property (win_a_active && $past(win_a_active)
    |-> win_sensitivity_level == alarm_seq_pkg::LEAST_SENSITIVE_LEVEL) else $error("level wrong");
  AST_MARCH_ON: assert property ($fell(notification_circuit[0]) && seen_q && circuit_coded[0]
    && coding_sel == alarm_seq_pkg::CODE_MARCH |-> hi_q == QTICK_CYCLES) else $error("march pulse wrong");
endmodule : alarm_seq_checker

bind alarm_output_sequencer alarm_seq_checker #(
  .NUM_CIRCUITS(NUM_CIRCUITS),
  .QTICK_CYCLES(QTICK_CYCLES)
) i_alarm_seq_checker (.*);

// file: test/appliance_load.sv
module appliance_load (
  input  wire logic  core_clk,
  input  wire logic  clr,
  input  wire logic  drive,
  output logic [15:0] on_len,
  output logic [15:0] off_max
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run_q = 16'h0000;
  logic        last_q = 1'b0;
  logic        seen_q = 1'b0;

  // lows count only between two highs, so idle time is never mistaken for a gap
  always_ff @(posedge core_clk) begin
    last_q <= drive;
    run_q  <= (drive == last_q) ? run_q + 16'h0001 : 16'h0001;
    if (clr) begin
      seen_q  <= 1'b0;
      on_len  <= 16'h0000;
      off_max <= 16'h0000;
    end else if (drive != last_q) begin
      if (last_q)
        on_len <= run_q;
      else if (seen_q && run_q > off_max)
        off_max <= run_q;
      if (last_q)
        seen_q <= 1'b1;
    end
  end
endmodule : appliance_load

// file: test/alarm_output_sequencer_tb.sv
module alarm_output_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                       core_clk = 1'b0;
  logic                       sys_rst = 1'b1;
  logic                       programming = 1'b0;
  logic                       posseq = 1'b0;
  logic                       clr = 1'b0;
  alarm_seq_pkg::panel_evt_t  evt = '0;
  alarm_seq_pkg::time_win_t   tw = '0;
  alarm_seq_pkg::coding_sel_t coding_sel = alarm_seq_pkg::CODE_MARCH;
  alarm_seq_pkg::remote_out_t rem;
  logic [3:0]                 c_seq = 4'h0;
  logic [3:0]                 c_win = 4'h0;
  logic [3:0]                 c_winb = 4'h0;
  logic [7:0]                 psec = 8'h28;
  logic [3:0]                 nc;
  logic [3:0]                 horn;
  logic [3:0]                 lvl;
  logic                       wa;
  logic                       dly;
  logic                       ss;
  logic [15:0]                on_len;
  logic [15:0]                off_max;
  int                         n_errors = 0;
  int                         check_count = 0;
  int                         cycles = 0;

  alarm_output_sequencer #(.QTICK_CYCLES(4)) i_alarm_output_sequencer (
    .core_clk(core_clk), .sys_rst(sys_rst), .evt(evt), .tw(tw), .programming(programming),
    .presignal_seconds(psec), .positive_alarm_sequence(posseq), .coding_sel(coding_sel),
    .circuit_coded(4'h3), .circuit_presignal(4'h4), .circuit_pas(c_seq), .circuit_win_a(c_win),
    .circuit_win_b(c_winb), .circuit_strobe(4'h1), .circuit_main_board(4'h1),
    .notification_circuit(nc), .horn_enable(horn), .remote_out(rem), .win_a_active(wa),
    .win_b_active(), .win_sensitivity_level(lvl), .delay_running(dly), .second_stage(ss));

  appliance_load i_appliance_load (.core_clk(core_clk), .clr(clr), .drive(nc[0]), .on_len(on_len),
    .off_max(off_max));

  // 20 MHz clock and a hang guard well past the longest escalation
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // one-cycle event pulse; returns on the edge that samples it
  task automatic fire(input logic [7:0] e);
    @(posedge core_clk);
    evt <= e;
    @(posedge core_clk);
    evt <= '0;
  endtask : fire

  // outputs are read mid-cycle, where they are settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : wait_n

  task automatic pat(input alarm_seq_pkg::coding_sel_t s, input logic [15:0] hi, input logic [15:0] lo);
    @(posedge core_clk);
    coding_sel <= s;
    clr <= 1'b1;
    fire(8'h80);
    clr <= 1'b0;
    wait_n(3 * (hi + lo));
    chk(on_len, hi);
    chk(off_max, lo);
    chk(nc[1], nc[0]);
    fire(8'h04);
  endtask : pat

  task automatic esc(input alarm_seq_pkg::coding_sel_t s, input logic [7:0] pre, input int n,
                     input logic [7:0] trig, input logic ex);
    @(posedge core_clk);
    coding_sel <= s;
    fire(8'h80);
    fire(pre);
    wait_n(n);
    fire(trig);
    wait_n(1);
    chk(ss, ex);
    fire(8'h04);
  endtask : esc

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    pat(alarm_seq_pkg::CODE_MARCH, 4, 4);
    pat(alarm_seq_pkg::CODE_TEMPORAL, 8, 24);
    pat(alarm_seq_pkg::CODE_CALIFORNIA, 160, 80);
    pat(alarm_seq_pkg::CODE_TWO_STAGE, 24, 24);
    // plain alarm: remotes at once, presignal circuit after the clamped minimum
    fire(8'h80);
    wait_n(1);
    chk(rem, 4'hF);
    chk(nc[3], 1'b1);
    wait_n(926);
    chk(nc[2], 1'b0);
    wait_n(50);
    chk(nc[2], 1'b1);
    fire(8'h04);
    // zone alarm holds the remotes until a second alarm
    fire(8'hC0);
    wait_n(100);
    chk(rem, 4'h0);
    chk(dly, 1'b1);
    fire(8'h80);
    wait_n(1);
    chk(rem, 4'hF);
    chk(nc[2], 1'b1);
    fire(8'h04);
    // positive sequence: short window, then acknowledge stretches to full delay
    posseq <= 1'b1;
    c_seq <= 4'h4;
    fire(8'hC0);
    wait_n(220);
    chk(nc[2], 1'b0);
    wait_n(40);
    chk(nc[2], 1'b1);
    chk(rem, 4'hF);
    fire(8'h04);
    fire(8'hC0);
    fire(8'h20);
    wait_n(260);
    chk(nc[2], 1'b0);
    wait_n(720);
    chk(nc[2], 1'b1);
    fire(8'h04);
    posseq <= 1'b0;
    // time window on a holiday, then holiday selector, programming, out of time
    c_win <= 4'h8;
    tw <= {7'h01, 1'b1, 1'b1, 1'b0, 8'h01, 8'h00};
    fire(8'h80);
    wait_n(2);
    chk(wa, 1'b0);
    @(posedge core_clk);
    tw.win_a_days <= 8'h81;
    wait_n(2);
    chk(wa, 1'b1);
    chk(lvl, 4'h9);
    chk(nc[3], 1'b1);
    @(posedge core_clk);
    programming <= 1'b1;
    wait_n(2);
    chk(wa, 1'b0);
    chk(nc[3], 1'b0);
    @(posedge core_clk);
    programming <= 1'b0;
    tw.win_a_in_time <= 1'b0;
    wait_n(2);
    chk(wa, 1'b0);
    chk(nc[3], 1'b0);
    fire(8'h04);
    c_win <= 4'h0;
    // sync modes: main-board strobe steady, horn-only silence, resound on alarm
    for (int k = 7; k < 10; k++) begin
      coding_sel <= alarm_seq_pkg::coding_sel_t'(k);
      fire(8'h80);
      wait_n(2);
      chk(nc[0], 1'b1);
      chk(nc[1], 1'b0);
      fire(8'h08);
      wait_n(1);
      chk(horn[0], 1'b0);
      chk(nc[0], 1'b1);
      fire(8'h80);
      wait_n(2);
      chk(horn[0], 1'b1);
      fire(8'h04);
    end
    esc(alarm_seq_pkg::CODE_CANADA5, 8'h00, 10, 8'h01, 1'b1);
    esc(alarm_seq_pkg::CODE_CANADA_MAN, 8'h10, 10, 8'h02, 1'b0);
    esc(alarm_seq_pkg::CODE_CANADA_MAN, 8'h00, 10, 8'h02, 1'b1);
    esc(alarm_seq_pkg::CODE_CANADA3, 8'h20, 2950, 8'h00, 1'b0);
    esc(alarm_seq_pkg::CODE_TWO_STAGE, 8'h00, 4850, 8'h00, 1'b1);
    end_sim();
  end
endmodule : alarm_output_sequencer_tb
